// *** core/acs_regs.vh ***
// Register map, field positions, reset values and timing counts of the converter controller.
// Assumes a 100 MHz i_mclk and a plain address/strobe register port with 4-bit addresses.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACS_REG_CTRL    4'h0
`define ACS_REG_CHAN    4'h1
`define ACS_REG_CMD     4'h2
`define ACS_REG_STAT    4'h3
`define ACS_REG_DATA    4'h4
`define ACS_REG_PACER   4'h5
`define ACS_REG_DOUT    4'h6
`define ACS_REG_GAIN    4'h8

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define ACS_CTRL_SRC_LSB  0
`define ACS_CTRL_SCAN_BIT 2
`define ACS_CMD_CONV_BIT  0
`define ACS_CMD_GO_BIT    1
`define ACS_CMD_HALT_BIT  2
`define ACS_SRC_SW        2'h0
`define ACS_SRC_INT       2'h1
`define ACS_SRC_EXT       2'h2
`define ACS_CTRL_RST      3'h0
`define ACS_CHAN_RST      6'h00
`define ACS_PACER_RST     16'h0019
`define ACS_GAIN_RST      4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ACS_CLK_MHZ       100
`define ACS_CONV_US       25
`define ACS_CONV_CYC      (`ACS_CONV_US * `ACS_CLK_MHZ)
`define ACS_TICK_US       1
`define ACS_TICK_CYC      (`ACS_TICK_US * `ACS_CLK_MHZ)
`define ACS_MUX_SETTLE    12'h004
// Last count of the 1 us tick divider, one below ACS_TICK_CYC
`define ACS_TICK_LAST     7'h63
// Last cycle of a conversion, one below ACS_CONV_CYC
`define ACS_CONV_LAST     12'h9C3

`endif

// *** core/acs_fifo.v ***
// Synchronous FIFO for conversion results.
// Assumes one clock and an active high asynchronous reset.
`include "acs_regs.vh"

module acs_fifo #(
	parameter WIDTH = 15,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             i_mclk,
	input  wire             i_rst,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage written without reset
	always @(posedge i_mclk) begin
		if (push)
			mem[wr_q] <= i_in_data;
	end

	// Pointers and fill count
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// *** core/acs_ctrl.v ***
// Converter controller: clock source, channel scan, gains, results.
// Assumes a converter front end with a start pulse and 12-bit parallel data, and an 8:1 multiplexer.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "acs_regs.vh"

module acs_ctrl (
	input  wire        i_mclk,
	input  wire        i_rst,
	input  wire [3:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rdata,
	input  wire        i_xclk,
	input  wire [11:0] i_adc_code,
	output reg         o_adc_start,
	output reg  [2:0]  o_mux_sel,
	output reg  [3:0]  o_gain,
	output reg  [3:0]  o_dout,
	output reg         o_done
);
	// ****************************************************************
	// States and helpers
	// ****************************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_PUSH = 2'h2;

	// Next scan channel, wrapping 7 to 0 and stop back to start
	function [2:0] next_chan;
		input [2:0] cur;
		input [2:0] first;
		input [2:0] last;
		begin
			if (cur == last)
				next_chan = first;
			else
				next_chan = cur + 3'h1;
		end
	endfunction

	reg [2:0]  ctrl_q;
	reg [5:0]  chan_q;
	reg [15:0] pacer_q;
	reg [3:0]  gain_q [0:7];
	reg        run_q;
	reg [1:0]  st_q;
	reg [11:0] cyc_q;
	reg [6:0]  tick_q;
	reg [16:0] down_q;
	reg [2:0]  cur_q;
	reg [2:0]  conv_ch_q;
	reg        pend_q;
	reg        ovr_q;
	reg        x1_q;
	reg        x2_q;
	reg        x3_q;
	reg        pop_q;
	wire       fifo_ready;
	wire       fifo_valid;
	wire [14:0] fifo_data;
	wire [1:0] src;
	wire       scan;
	wire       x_fall;
	wire       tick;
	wire       trig;
	wire       wr_cmd;
	integer    gi;

	assign src    = ctrl_q[`ACS_CTRL_SRC_LSB +: 2];
	assign scan   = ctrl_q[`ACS_CTRL_SCAN_BIT];
	assign x_fall = x3_q & ~x2_q;
	assign tick   = (tick_q == 7'd0);
	assign wr_cmd = i_wr & (i_addr == `ACS_REG_CMD);

	// ****************************************************************
	// External clock synchroniser and falling edge
	// ****************************************************************
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			x1_q <= 1'b1;
			x2_q <= 1'b1;
			x3_q <= 1'b1;
		end else begin
			x1_q <= i_xclk;
			x2_q <= x1_q;
			x3_q <= x2_q;
		end
	end

	// Conversion request from the selected source
	assign trig = (src == `ACS_SRC_SW)  ? (wr_cmd & i_wdata[`ACS_CMD_CONV_BIT]) :
		      (src == `ACS_SRC_INT) ? (run_q & tick & (down_q == 17'd1)) :
		      (src == `ACS_SRC_EXT) ? (run_q & x_fall) : 1'b0;

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q  <= `ACS_CTRL_RST;
			chan_q  <= `ACS_CHAN_RST;
			pacer_q <= `ACS_PACER_RST;
			o_dout  <= 4'h0;
			run_q   <= 1'b0;
			for (gi = 0; gi < 8; gi = gi + 1)
				gain_q[gi] <= `ACS_GAIN_RST;
		end else if (i_wr) begin
			case (i_addr)
			`ACS_REG_CTRL:  ctrl_q  <= i_wdata[2:0];
			`ACS_REG_CHAN:  chan_q  <= i_wdata[5:0];
			`ACS_REG_PACER: pacer_q <= i_wdata;
			`ACS_REG_DOUT:  o_dout  <= i_wdata[3:0];
			`ACS_REG_CMD: begin
				if (i_wdata[`ACS_CMD_GO_BIT])
					run_q <= 1'b1;
				if (i_wdata[`ACS_CMD_HALT_BIT])
					run_q <= 1'b0;
			end
			default: begin
				if (i_addr[3])
					gain_q[i_addr[2:0]] <= i_wdata[3:0];
			end
			endcase
		end
	end

	// ****************************************************************
	// Internal pacer: 1 MHz tick and down-counter
	// ****************************************************************
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tick_q <= 7'd0;
			down_q <= 17'd0;
		end else if (!run_q || src != `ACS_SRC_INT) begin
			tick_q <= 7'd0;
			down_q <= {1'b0, pacer_q};
		end else begin
			tick_q <= tick ? `ACS_TICK_LAST : tick_q - 7'h01;
			if (tick)
				down_q <= (down_q <= 17'd1) ? {1'b0, pacer_q} : down_q - 17'd1;
		end
	end

	// ****************************************************************
	// Conversion sequencer and channel scan
	// ****************************************************************
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_q        <= ST_IDLE;
			cyc_q       <= 12'd0;
			cur_q       <= 3'h0;
			conv_ch_q   <= 3'h0;
			pend_q      <= 1'b0;
			ovr_q       <= 1'b0;
			o_done      <= 1'b0;
			o_adc_start <= 1'b0;
			o_mux_sel   <= 3'h0;
			o_gain      <= `ACS_GAIN_RST;
		end else begin
			o_adc_start <= 1'b0;
			if (i_wr && i_addr == `ACS_REG_CHAN)
				cur_q <= i_wdata[2:0];
			if (i_rd && i_addr == `ACS_REG_STAT)
				ovr_q <= 1'b0;
			if (trig && st_q != ST_IDLE)
				pend_q <= 1'b1;
			case (st_q)
			ST_IDLE: begin
				o_mux_sel <= scan ? cur_q : chan_q[2:0];
				// Scan keeps the start channel's gain for the whole range
				o_gain    <= gain_q[chan_q[2:0]];
				if (trig || pend_q) begin
					pend_q      <= 1'b0;
					o_adc_start <= 1'b1;
					o_done      <= 1'b0;
					conv_ch_q   <= scan ? cur_q : chan_q[2:0];
					cyc_q       <= 12'd0;
					st_q        <= ST_CONV;
				end
			end
			ST_CONV: begin
				cyc_q <= cyc_q + 12'd1;
				if (scan && cyc_q == `ACS_MUX_SETTLE) begin
					cur_q     <= next_chan(cur_q, chan_q[2:0], chan_q[5:3]);
					o_mux_sel <= next_chan(cur_q, chan_q[2:0], chan_q[5:3]);
				end
				if (cyc_q == `ACS_CONV_LAST)
					st_q <= ST_PUSH;
			end
			ST_PUSH: begin
				if (!fifo_ready)
					ovr_q <= 1'b1;
				o_done <= 1'b1;
				st_q   <= ST_IDLE;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Result FIFO and register reads
	// ****************************************************************
	acs_fifo #(
		.WIDTH (15),
		.DEPTH (8),
		.AW    (3)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_in_valid  (st_q == ST_PUSH),
		.o_in_ready  (fifo_ready),
		.i_in_data   ({conv_ch_q, i_adc_code}),
		.o_out_valid (fifo_valid),
		.i_out_ready (pop_q),
		.o_out_data  (fifo_data)
	);

	// Pop one word after a data read has been answered
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			pop_q <= 1'b0;
		else
			pop_q <= i_rd & (i_addr == `ACS_REG_DATA) & fifo_valid;
	end

	// Read data stand one cycle after the strobe
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			case (i_addr)
			`ACS_REG_CTRL:  o_rdata <= {13'h0000, ctrl_q};
			`ACS_REG_CHAN:  o_rdata <= {10'h000, chan_q};
			`ACS_REG_STAT:  o_rdata <= {10'h000, cur_q, ovr_q, fifo_valid, o_done};
			`ACS_REG_DATA:  o_rdata <= {fifo_valid, fifo_data};
			`ACS_REG_PACER: o_rdata <= pacer_q;
			`ACS_REG_DOUT:  o_rdata <= {12'h000, o_dout};
			default:        o_rdata <= i_addr[3] ? {12'h000, gain_q[i_addr[2:0]]} : 16'h0000;
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end
endmodule

// *** bench/acs_adc_model.sv ***
// Converter front end model: returns a code that names its channel.
// Assumes one o_adc_start pulse per conversion, result sampled at its end.
module acs_adc_model (
	input  wire logic        i_mclk,
	input  wire logic        i_start,
	input  wire logic [2:0]  i_mux,
	output logic      [11:0] o_code
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_code = 12'h000;
	// Hold input at start; the code carries the sampled channel
	always @(posedge i_mclk) begin
		if (i_start) begin
			o_code <= 12'hA00 | {9'h000, i_mux};
		end
	end
endmodule

// *** bench/acs_ctrl_sva.sv ***
// Checker of the converter controller's port timing.
// Assumes the 2500-cycle conversion and one-cycle read data of the design.
module acs_ctrl_sva (
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_adc_start,
	input wire logic [2:0]  o_mux_sel,
	input wire logic [3:0]  o_dout,
	input wire logic        o_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic [11:0] cnt_q;
	// Cycles since the last conversion start, saturating
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) cnt_q <= 12'hFFF;
		else if (o_adc_start) cnt_q <= 12'h000;
		else if (cnt_q != 12'hFFF) cnt_q <= cnt_q + 12'h001;
	end
	start_pulse_a: assert property (o_adc_start |=> !o_adc_start) else $error("start wide");
	conv_gap_a: assert property (o_adc_start && cnt_q != 12'hFFF |-> cnt_q >= 12'd2499)
		else $error("starts too close");
	done_time_a: assert property ($rose(o_done) |-> cnt_q inside {[12'd2498:12'd2503]})
		else $error("done at wrong time");
	start_done_a: assert property (o_adc_start |-> !o_done) else $error("done at start");
	done_fall_a: assert property ($fell(o_done) |-> o_adc_start) else $error("done fell");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata");
	dout_write_a: assert property (i_wr && i_addr == 4'h6 |=> o_dout == $past(i_wdata[3:0]))
		else $error("dout");
	mux_hold_a: assert property (cnt_q > 12'd10 && cnt_q < 12'd2400 && !$past(i_wr)
		&& !$past(i_wr, 2)
		|-> $stable(o_mux_sel)) else $error("mux moved mid conversion");
	cover property (o_adc_start ##5 $changed(o_mux_sel));
	cover property ($rose(o_done));
	cover property (o_adc_start && cnt_q == 12'd2999);
endmodule
bind acs_ctrl acs_ctrl_sva u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_adc_start(o_adc_start),
	.o_mux_sel(o_mux_sel), .o_dout(o_dout), .o_done(o_done));

// *** bench/tb_acs_ctrl.sv ***
// Testbench of the converter controller: register tasks and scenarios.
// Assumes the controller's register map header and the converter model.
`include "acs_regs.vh"
module tb_acs_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_xclk = 1, o_adc_start, o_done;
	logic [3:0]  i_addr = 0, o_gain, o_dout;
	logic [15:0] i_wdata = 0, o_rdata, v;
	logic [11:0] i_adc_code;
	logic [2:0]  o_mux_sel;
	int          n_mismatch = 0, checked = 0, cyc = 0, t0, i;
	bit          hit;
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) cyc <= cyc + 1;
	acs_ctrl uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_xclk(i_xclk), .i_adc_code(i_adc_code),
		.o_adc_start(o_adc_start), .o_mux_sel(o_mux_sel), .o_gain(o_gain), .o_dout(o_dout),
		.o_done(o_done));
	acs_adc_model u_adc (.i_mclk(i_mclk), .i_start(o_adc_start), .i_mux(o_mux_sel),
		.o_code(i_adc_code));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a; i_wdata <= d; i_wr <= 1;
		@(posedge i_mclk);
		i_wr <= 0;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [3:0] a);
		i_addr <= a; i_rd <= 1;
		@(posedge i_mclk);
		i_rd <= 0;
		#1 v = o_rdata;
		@(posedge i_mclk);
	endtask
	task automatic poll;
		for (i = 0; i < 3000; i++) begin
			rd(`ACS_REG_STAT);
			if (v[0] === 1'b1) break;
		end
	endtask
	task automatic wait_start(input int lim);
		hit = 0;
		for (i = 0; i < lim && !hit; i++) begin
			@(negedge i_mclk);
			hit = (o_adc_start === 1'b1);
		end
		t0 = cyc;
		@(posedge i_mclk);
	endtask
	task final_report;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge i_mclk);
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst <= 0;
		@(posedge i_mclk);
		rd(`ACS_REG_CTRL); chk("ctrl", v, 16'h0000);
		rd(`ACS_REG_PACER); chk("pacer", v, 16'h0019);
		rd(4'h7); chk("unmapped", v, 16'h0000);
		for (int c = 0; c < 8; c++) wr(4'h8 + c[3:0], 16'h0001 + c[15:0]);
		for (int c = 0; c < 8; c++) begin
			rd(4'h8 + c[3:0]); chk("gain", v, 16'h0001 + c[15:0]);
		end
		wr(`ACS_REG_DOUT, 16'h0005); chk("dout", {12'h000, o_dout}, 16'h0005);
		$display("registers done");
		wr(`ACS_REG_CHAN, 16'h0003); wr(`ACS_REG_CMD, 16'h0001); wait_start(10);
		chk("gain out", {12'h000, o_gain}, 16'h0004);
		poll; rd(`ACS_REG_DATA); chk("single", v, 16'hBA03);
		$display("single done");
		wr(`ACS_REG_CTRL, 16'h0004); wr(`ACS_REG_CHAN, 16'h000E);
		for (int k = 0; k < 5; k++) begin
			logic [2:0] ch;
			ch = (k == 4) ? 3'd6 : 3'(6 + k);
			wr(`ACS_REG_CMD, 16'h0001); wait_start(10);
			chk("scan gain", {12'h000, o_gain}, 16'h0007);
			poll; rd(`ACS_REG_DATA);
			chk("scan", v, {1'b1, ch, 12'hA00 | {9'h000, ch}});
		end
		$display("scan done");
		wr(`ACS_REG_PACER, 16'd30); wr(`ACS_REG_CTRL, 16'h0001); wr(`ACS_REG_CMD, 16'h0002);
		wait_start(3100); v = t0;
		wait_start(3100); chk("pacing", 16'(t0 - v), 16'd3000);
		repeat (8) wait_start(3100);
		wr(`ACS_REG_CMD, 16'h0004); repeat (2600) @(posedge i_mclk);
		rd(`ACS_REG_STAT); chk("overrun", v & 16'h0007, 16'h0007);
		repeat (8) begin
			rd(`ACS_REG_DATA); chk("drain", v, 16'hEA06);
		end
		rd(`ACS_REG_STAT); chk("empty", v & 16'h0002, 16'h0000);
		$display("internal done");
		wr(`ACS_REG_CTRL, 16'h0002); wr(`ACS_REG_CMD, 16'h0002);
		wait_start(300); chk("armed only", {15'h0, hit}, 16'h0000);
		repeat (2) begin
			i_xclk <= 0; wait_start(10); chk("xclk start", {15'h0, hit}, 16'h0001);
			repeat (2600) @(posedge i_mclk);
			i_xclk <= 1; repeat (20) @(posedge i_mclk);
		end
		$display("external done");
		final_report;
	end
endmodule
